// ===== design/rre_exec.sv
// rotate, return-with-immediate and interrupt-return execution unit
//
// Function
// - A return with immediate pops the stack into the pc, loads the immediate into work_register_a and touches no flag.
// - An interrupt return pops the stack into the pc and sets global_irq_gate to one, touching no flag.
// - If an interrupt is pending at an interrupt return, it is serviced before the main program resumes.
// - Rotate-left to memory moves every bit up one place, bit 7 into bit 0, writes memory and keeps flags.
// - Rotate-left to work_register_a does the same rotation into work_register_a and leaves memory alone.
// - Rotate-left through carry to memory puts old bit 7 in carry and old carry in bit 0, writing memory.
// - Rotate-left through carry to work_register_a does the same into work_register_a, memory unchanged.
// - Rotate-right to memory moves every bit down one place, bit 0 into bit 7, writes memory and keeps flags.
// - Rotate-right to work_register_a does the same rotation without carry into work_register_a.
// - Rotate-right through carry to memory puts old bit 0 in carry and old carry in bit 7, writing memory.
// - Rotate-right through carry to work_register_a does the same into work_register_a, memory unchanged.
`timescale 1ns/1ps

module rre_exec (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // instruction handshake
  input wire logic instr_valid,
  output logic instr_ready,
  input wire rre_pkg::rre_op_e instr_op,
  input wire logic [7:0] instr_addr,
  input wire logic [7:0] instr_imm,
  output logic instr_done,
  // return stack push from call logic
  input wire logic push_valid,
  input wire logic [11:0] push_pc,
  // data memory
  output logic [7:0] mem_addr,
  input wire logic [7:0] mem_rd_data,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  // interrupt controller side
  input wire logic irq_pending,
  input wire logic [11:0] irq_vector,
  output logic irq_ack,
  // core state
  output logic [7:0] work_register_a,
  output logic carry_flag,
  output logic global_irq_gate,
  output logic [11:0] pc,
  output logic [2:0] stack_level
);

  rre_pkg::rre_state_s state_r;
  rre_pkg::rre_state_s state_nxt;

  // rotate core: returns {carry_out, byte}
  function automatic logic [8:0] rre_rotate(
    input rre_pkg::rre_op_e op,
    input logic [7:0] d,
    input logic c
  );
    logic [8:0] r;
    r = {c, d};
    case (op)
      rre_pkg::OP_ROL_MEM,
      rre_pkg::OP_ROL_A: begin
        r = {c, d[6:0], d[rre_pkg::MSB]};
      end
      rre_pkg::OP_ROLC_MEM,
      rre_pkg::OP_ROLC_A: begin
        r = {d[rre_pkg::MSB], d[6:0], c};
      end
      rre_pkg::OP_ROR_MEM,
      rre_pkg::OP_ROR_A: begin
        r = {c, d[rre_pkg::LSB], d[7:1]};
      end
      rre_pkg::OP_RORC_MEM,
      rre_pkg::OP_RORC_A: begin
        r = {d[rre_pkg::LSB], c, d[7:1]};
      end
      default: begin
        r = {c, d};
      end
    endcase
    return r;
  endfunction : rre_rotate

  // destination decode: work_register_a or memory
  function automatic logic rre_to_acc(input rre_pkg::rre_op_e op);
    logic a;
    case (op)
      rre_pkg::OP_ROL_A,
      rre_pkg::OP_ROLC_A,
      rre_pkg::OP_ROR_A,
      rre_pkg::OP_RORC_A: a = 1'b1;
      default: a = 1'b0;
    endcase
    return a;
  endfunction : rre_to_acc

  // which ops change carry
  function automatic logic rre_thru_carry(input rre_pkg::rre_op_e op);
    logic t;
    case (op)
      rre_pkg::OP_ROLC_MEM,
      rre_pkg::OP_ROLC_A,
      rre_pkg::OP_RORC_MEM,
      rre_pkg::OP_RORC_A: t = 1'b1;
      default: t = 1'b0;
    endcase
    return t;
  endfunction : rre_thru_carry

  // return-type ops
  function automatic logic rre_is_ret(input rre_pkg::rre_op_e op);
    return (op == rre_pkg::OP_RET_IMM) || (op == rre_pkg::OP_IRQ_RET);
  endfunction : rre_is_ret

  always_comb begin
    logic [8:0] rot;
    logic [2:0] sp_dec;
    rot = 9'h000;
    sp_dec = 3'h0;
    state_nxt = state_r;
    state_nxt.mem_we = 1'b0;
    state_nxt.irq_ack = 1'b0;
    state_nxt.done = 1'b0;
    rot = rre_rotate(state_r.op, mem_rd_data, state_r.carry);
    sp_dec = (state_r.sp == rre_pkg::SP_RST) ? rre_pkg::SP_RST : state_r.sp - 3'h1;
    case (state_r.st)
      rre_pkg::ST_IDLE: begin
        if (instr_valid) begin
          state_nxt.op = instr_op;
          state_nxt.imm = instr_imm;
          state_nxt.mem_addr = instr_addr;
          if (rre_is_ret(instr_op)) begin
            state_nxt.st = rre_pkg::ST_RET;
          end else if (instr_op != rre_pkg::OP_NONE) begin
            state_nxt.st = rre_pkg::ST_EXEC;
          end else begin
            state_nxt.done = 1'b1;
          end
        end else if (push_valid && state_r.sp != rre_pkg::SP_FULL) begin
          state_nxt.stk[state_r.sp] = push_pc;
          state_nxt.sp = state_r.sp + 3'h1;
        end
      end
      rre_pkg::ST_EXEC: begin
        // memory byte has arrived; commit destination and carry together
        if (rre_to_acc(state_r.op)) begin
          state_nxt.acc = rot[7:0];
        end else begin
          state_nxt.mem_we = 1'b1;
          state_nxt.mem_wdata = rot[7:0];
        end
        if (rre_thru_carry(state_r.op)) begin
          state_nxt.carry = rot[rre_pkg::ROT_CARRY_BIT];
        end
        state_nxt.done = 1'b1;
        state_nxt.st = rre_pkg::ST_IDLE;
      end
      rre_pkg::ST_RET: begin
        // pop; an empty stack yields its bottom entry
        state_nxt.pc = state_r.stk[sp_dec];
        state_nxt.sp = sp_dec;
        if (state_r.op == rre_pkg::OP_RET_IMM) begin
          state_nxt.acc = state_r.imm;
          state_nxt.done = 1'b1;
          state_nxt.st = rre_pkg::ST_IDLE;
        end else begin
          state_nxt.irq_gate = 1'b1;
          if (irq_pending) begin
            state_nxt.st = rre_pkg::ST_IRQ;
          end else begin
            state_nxt.done = 1'b1;
            state_nxt.st = rre_pkg::ST_IDLE;
          end
        end
      end
      rre_pkg::ST_IRQ: begin
        // enter the pending handler; the restored pc is the return point
        if (state_r.sp != rre_pkg::SP_FULL) begin
          state_nxt.stk[state_r.sp] = state_r.pc;
          state_nxt.sp = state_r.sp + 3'h1;
        end
        state_nxt.pc = irq_vector;
        state_nxt.irq_gate = 1'b0;
        state_nxt.irq_ack = 1'b1;
        state_nxt.done = 1'b1;
        state_nxt.st = rre_pkg::ST_IDLE;
      end
      default: begin
        state_nxt.st = rre_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r.st <= rre_pkg::ST_IDLE;
      state_r.op <= rre_pkg::OP_NONE;
      state_r.imm <= rre_pkg::ACC_RST;
      state_r.acc <= rre_pkg::ACC_RST;
      state_r.carry <= rre_pkg::CARRY_RST;
      state_r.irq_gate <= rre_pkg::IRQ_GATE_RST;
      state_r.pc <= rre_pkg::PC_RST;
      state_r.sp <= rre_pkg::SP_RST;
      state_r.stk <= '0;
      state_r.mem_addr <= rre_pkg::ACC_RST;
      state_r.mem_wdata <= rre_pkg::ACC_RST;
      state_r.mem_we <= 1'b0;
      state_r.irq_ack <= 1'b0;
      state_r.done <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign instr_ready = (state_r.st == rre_pkg::ST_IDLE);
  assign instr_done = state_r.done;
  assign mem_addr = state_r.mem_addr;
  assign mem_we = state_r.mem_we;
  assign mem_wdata = state_r.mem_wdata;
  assign irq_ack = state_r.irq_ack;
  assign work_register_a = state_r.acc;
  assign carry_flag = state_r.carry;
  assign global_irq_gate = state_r.irq_gate;
  assign pc = state_r.pc;
  assign stack_level = state_r.sp;

endmodule : rre_exec

// ===== pkg/rre_pkg.sv
// shared constants and types for the rotate and return execution unit
package rre_pkg;

  localparam int DATA_W = 8;
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 6;
  localparam int SP_W = 3;

  // values after reset, and the stack-full level
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic CARRY_RST = 1'b0;
  localparam logic IRQ_GATE_RST = 1'b0;
  localparam logic [11:0] PC_RST = 12'h000;
  localparam logic [2:0] SP_RST = 3'h0;
  localparam logic [2:0] SP_FULL = 3'h6;

  // field positions in the rotate result
  localparam int ROT_CARRY_BIT = 8;
  localparam int MSB = 7;
  localparam int LSB = 0;

  // instruction codes handed to the unit
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_RET_IMM = 4'h1,
    OP_IRQ_RET = 4'h2,
    OP_ROL_MEM = 4'h3,
    OP_ROL_A = 4'h4,
    OP_ROLC_MEM = 4'h5,
    OP_ROLC_A = 4'h6,
    OP_ROR_MEM = 4'h7,
    OP_ROR_A = 4'h8,
    OP_RORC_MEM = 4'h9,
    OP_RORC_A = 4'ha
  } rre_op_e;

  // one-hot sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_RET = 4'b0100,
    ST_IRQ = 4'b1000
  } rre_state_e;

  typedef struct packed {
    rre_state_e st;
    rre_op_e op;
    logic [7:0] imm;
    logic [7:0] acc;
    logic carry;
    logic irq_gate;
    logic [11:0] pc;
    logic [2:0] sp;
    logic [5:0][11:0] stk;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic irq_ack;
    logic done;
  } rre_state_s;

endpackage : rre_pkg

// ===== tb/rre_exec_props.sv
// checker for the rotate and return execution unit
`timescale 1ns/1ps
module rre_exec_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // instruction side
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire rre_pkg::rre_op_e instr_op,
  input wire logic [7:0] instr_imm,
  input wire logic instr_done,
  // memory and interrupt side
  input wire logic [7:0] mem_rd_data,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic irq_pending,
  input wire logic [11:0] irq_vector,
  input wire logic irq_ack,
  // core state
  input wire logic [7:0] work_register_a,
  input wire logic carry_flag,
  input wire logic global_irq_gate,
  input wire logic [11:0] pc
);
  logic [7:0] rd_r;
  logic c_r;
  wire tk = instr_valid && instr_ready;
  always_ff @(posedge ref_clk) begin
    rd_r <= mem_rd_data;
    c_r <= carry_flag;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_rot_done_lat: assert property (tk && instr_op >= rre_pkg::OP_ROL_MEM |->
    ##1 !instr_done ##1 instr_done) else $error("rotate done");
  a_rolc_mem_res: assert property (tk && instr_op == rre_pkg::OP_ROLC_MEM |-> ##2
    mem_we && mem_wdata == {rd_r[6:0], c_r} && carry_flag == rd_r[7]) else $error("rolc mem");
  a_rorc_acc_res: assert property (tk && instr_op == rre_pkg::OP_RORC_A |-> ##2
    work_register_a == {c_r, rd_r[7:1]} && carry_flag == rd_r[0]) else $error("rorc acc");
  a_rol_acc_res: assert property (tk && instr_op == rre_pkg::OP_ROL_A |-> ##2
    work_register_a == {rd_r[6:0], rd_r[7]} && !mem_we && $stable(carry_flag)) else $error("rol");
  a_ror_mem_res: assert property (tk && instr_op == rre_pkg::OP_ROR_MEM |-> ##2
    mem_we && mem_wdata == {rd_r[0], rd_r[7:1]} && $stable(carry_flag)) else $error("ror mem");
  a_ret_imm_load: assert property (tk && instr_op == rre_pkg::OP_RET_IMM |-> ##2
    work_register_a == $past(instr_imm, 2) && $stable(carry_flag)) else $error("ret imm");
  a_gate_set_plain: assert property (tk && instr_op == rre_pkg::OP_IRQ_RET ##1 !irq_pending
    |-> ##1 global_irq_gate && instr_done) else $error("gate");
  a_irq_entry_first: assert property (tk && instr_op == rre_pkg::OP_IRQ_RET ##1 irq_pending
    |-> ##1 !instr_done ##1 irq_ack && pc == $past(irq_vector)) else $error("irq entry");
endmodule : rre_exec_props
bind rre_exec rre_exec_props u_props (.ref_clk(ref_clk), .rst_b(rst_b),
  .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_op(instr_op),
  .instr_imm(instr_imm), .instr_done(instr_done), .mem_rd_data(mem_rd_data), .mem_we(mem_we),
  .mem_wdata(mem_wdata), .irq_pending(irq_pending), .irq_vector(irq_vector), .irq_ack(irq_ack),
  .work_register_a(work_register_a), .carry_flag(carry_flag),
  .global_irq_gate(global_irq_gate), .pc(pc));

// ===== tb/rre_exec_tb_top.sv
// self-checking bench for the rotate and return execution unit
`timescale 1ns/1ps
module rre_exec_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic instr_valid = 1'b0, push_valid = 1'b0, irq_pending = 1'b0, mc = 1'b0;
  rre_pkg::rre_op_e instr_op = rre_pkg::OP_NONE;
  logic [7:0] instr_addr = 8'h00, instr_imm = 8'h00, mem_rd_data = 8'h00, ma = 8'h00;
  logic [11:0] push_pc = 12'h000, irq_vector = 12'h000;
  logic instr_ready, instr_done, mem_we, irq_ack, carry_flag, global_irq_gate;
  logic [7:0] mem_addr, mem_wdata, work_register_a;
  logic [11:0] pc;
  logic [2:0] stack_level;
  int n_errors = 0, tests_run = 0, cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  rre_exec dut (.ref_clk(ref_clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr_op(instr_op), .instr_addr(instr_addr),
    .instr_imm(instr_imm), .instr_done(instr_done), .push_valid(push_valid), .push_pc(push_pc),
    .mem_addr(mem_addr), .mem_rd_data(mem_rd_data), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .irq_pending(irq_pending), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .work_register_a(work_register_a), .carry_flag(carry_flag),
    .global_irq_gate(global_irq_gate), .pc(pc), .stack_level(stack_level));
  task automatic give_verdict();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one request, operand byte held on the read port, bounded wait for done
  task automatic run(input rre_pkg::rre_op_e op, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_addr <= a;
    instr_imm <= d;
    mem_rd_data <= d;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    chk(instr_ready, op == rre_pkg::OP_NONE);
    k = 0;
    while (instr_done !== 1'b1 && k < 6) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk(instr_done, 1'b1);
  endtask : run
  task automatic push(input logic [11:0] v);
    @(posedge ref_clk);
    push_valid <= 1'b1;
    push_pc <= v;
    @(posedge ref_clk);
    push_valid <= 1'b0;
  endtask : push
  // all eight rotates, carry entering and leaving both ways
  task automatic rot_all();
    logic [7:0] d, r;
    logic nc;
    for (int i = 3; i <= 10; i++) begin
      d = (i % 2) ? 8'h81 : 8'h4e;
      r = i < 5 ? {d[6:0], d[7]} : i < 7 ? {d[6:0], mc} : i < 9 ? {d[0], d[7:1]} : {mc, d[7:1]};
      nc = (i == 5 || i == 6) ? d[7] : i > 8 ? d[0] : mc;
      run(rre_pkg::rre_op_e'(4'(i)), 8'(i), d);
      if (i % 2) begin
        chk(mem_we, 1'b1);
        chk(mem_wdata, r);
      end else begin
        ma = r;
        chk(mem_we, 1'b0);
      end
      chk(work_register_a, ma);
      chk(carry_flag, nc);
      chk(mem_addr, 8'(i));
      mc = nc;
    end
  endtask : rot_all
  task automatic ret_imm();
    push(12'h3a5);
    push(12'h17c);
    run(rre_pkg::OP_RET_IMM, 8'h00, 8'h5a);
    ma = 8'h5a;
    chk(pc, 12'h17c);
    chk(work_register_a, ma);
    chk(carry_flag, mc);
    chk(stack_level, 3'h1);
  endtask : ret_imm
  task automatic irq_ret(input logic p);
    push(12'h2c4);
    irq_vector <= 12'h040;
    irq_pending <= p;
    run(rre_pkg::OP_IRQ_RET, 8'h00, 8'h00);
    chk(pc, p ? 12'h040 : 12'h2c4);
    chk(global_irq_gate, !p);
    chk(irq_ack, p);
    chk(carry_flag, mc);
    chk(stack_level, {2'b00, p} + 3'h1);
    @(posedge ref_clk);
    irq_pending <= 1'b0;
  endtask : irq_ret
  // no-op request: one-cycle completion, nothing but mem_addr moves
  task automatic nop_op();
    run(rre_pkg::OP_NONE, 8'h33, 8'hc3);
    chk(mem_we, 1'b0);
    chk(work_register_a, ma);
    chk(carry_flag, mc);
    chk(pc, 12'h040);
    chk(mem_addr, 8'h33);
  endtask : nop_op
  // reset in mid-run: state back to its reset values
  task automatic reset_mid();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk(pc, 12'h000);
    chk(work_register_a, 8'h00);
    chk(carry_flag, 1'b0);
    chk(global_irq_gate, 1'b0);
    chk(stack_level, 3'h0);
    chk(instr_ready, 1'b1);
    chk(instr_done, 1'b0);
    chk(mem_we, 1'b0);
    chk(irq_ack, 1'b0);
    ma = 8'h00;
    mc = 1'b0;
  endtask : reset_mid
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    rot_all();
    ret_imm();
    irq_ret(1'b0);
    irq_ret(1'b1);
    nop_op();
    reset_mid();
    repeat (7) push(12'h0ff);
    #1;
    chk(stack_level, 3'h6);
    give_verdict();
  end
endmodule : rre_exec_tb_top
